// [core/cbh_cfg_header.v]
// Purpose: Header registers 09h-14h of both bridge functions, tenure limit
// Assumes: One-cycle configuration strobes, dword address, byte enables
// Notes: Read data is registered one cycle after the read strobe
`timescale 1ns/10ps
`include "cbh_cfg_map.vh"
// Functional notes
// - The category code reads 060700h in each function and ignores writes.
// - The host line length byte stores what software writes and resets to 00h.
// - As initiator the tenure counter starts from zero at FRAME and counts clocks.
// - After the tenure count expires the transfer ends once GNT is deasserted.
// - The layout kind byte always reads 82h and is read-only.
// - Offsets up to 7Fh are standard header, 80h-FFh are extension space.
// - The self-test byte reads 00h in both functions and ignores writes.
// - Window base bits 31-12 are writable and readable on a 4-Kbyte boundary.
// - Window base bits 11-0 read zero so all ones reads back FFFF F000h.
// - The window decodes socket registers from 000h and legacy ones from 800h.
// - Each function holds its own independent window base register.
// - The capability pointer always reads A0h.
// - Both functions share the one fixed capability pointer value.
module cbh_cfg_header #(
    parameter NFUNC = 2
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Configuration access
    input wire cfg_rd,
    input wire cfg_wr,
    input wire cfg_func,
    input wire [5:0] cfg_dw,
    input wire [3:0] cfg_be,
    input wire [31:0] cfg_wdata,
    output reg [31:0] cfg_rdata,
    output reg cfg_ack,
    output reg cfg_ext_sel,
    // Memory window decode
    input wire [31:0] mem_addr,
    input wire mem_req,
    output reg [1:0] win_hit_socket,
    output reg [1:0] win_hit_legacy,
    // Initiator tenure
    input wire init_frame_start,
    input wire init_busy,
    input wire gnt_n,
    output reg init_end_req,
    output reg [7:0] line_len_out
);
    // ****************************************
    // Reset synchroniser
    // ****************************************
    reg rst_s1_ff;
    reg rst_s2_ff;
    wire rst_sync_n;

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end
        else
        begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    assign rst_sync_n = rst_s2_ff;

    // ****************************************
    // Per-function registers
    // ****************************************
    reg [7:0] line_len_ff [0:NFUNC-1];
    reg [7:0] tenure_ff [0:NFUNC-1];
    reg [19:0] win_base_ff [0:NFUNC-1];
    wire [NFUNC-1:0] hit_sock;
    wire [NFUNC-1:0] hit_leg;

    genvar f;
    generate
        for (f = 0; f < NFUNC; f = f + 1)
        begin : g_func
            wire sel;
            wire in_win;
            assign sel = cfg_wr && ({31'h00000000, cfg_func} == f);
            always @(posedge ref_clk or negedge rst_sync_n)
            begin
                if (!rst_sync_n)
                begin
                    line_len_ff[f] <= `CBH_RST_LINE_LEN;
                    tenure_ff[f] <= `CBH_RST_TENURE;
                    win_base_ff[f] <= `CBH_RST_WINBASE;
                end
                else if (sel)
                begin
                    if (cfg_dw == `CBH_DW_MISC)
                    begin
                        if (cfg_be[0])
                            line_len_ff[f] <= cfg_wdata[7:0];
                        if (cfg_be[1])
                            tenure_ff[f] <= cfg_wdata[15:8];
                    end
                    if (cfg_dw == `CBH_DW_WINBASE)
                    begin
                        if (cfg_be[1])
                            win_base_ff[f][3:0] <= cfg_wdata[15:12];
                        if (cfg_be[2])
                            win_base_ff[f][11:4] <= cfg_wdata[23:16];
                        if (cfg_be[3])
                            win_base_ff[f][19:12] <= cfg_wdata[31:24];
                    end
                end
            end
            assign in_win = mem_req &&
                (mem_addr[`CBH_WIN_MSB:`CBH_WIN_LSB] == win_base_ff[f]);
            assign hit_sock[f] = in_win && !mem_addr[`CBH_WIN_SEL_BIT];
            assign hit_leg[f] = in_win && mem_addr[`CBH_WIN_SEL_BIT];
        end
    endgenerate

    // ****************************************
    // Read mux
    // ****************************************
    reg [31:0] nxt_rdata;
    reg nxt_ext;

    always @*
    begin
        nxt_rdata = 32'h00000000;
        nxt_ext = (cfg_dw[5] == 1'b1);
        case (cfg_dw)
            `CBH_DW_CLASS:
                nxt_rdata = {`CBH_RST_CATEGORY, 8'h00};
            `CBH_DW_MISC:
                nxt_rdata = {`CBH_RST_SELF_TEST, `CBH_RST_LAYOUT,
                    tenure_ff[cfg_func], line_len_ff[cfg_func]};
            `CBH_DW_WINBASE:
                nxt_rdata = {win_base_ff[cfg_func], 12'h000};
            `CBH_DW_CAP:
                nxt_rdata = {24'h000000, `CBH_RST_CAP_PTR};
            default:
                nxt_rdata = 32'h00000000;
        endcase
    end

    always @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            cfg_rdata <= 32'h00000000;
            cfg_ack <= 1'b0;
            cfg_ext_sel <= 1'b0;
            win_hit_socket <= 2'b00;
            win_hit_legacy <= 2'b00;
            line_len_out <= 8'h00;
        end
        else
        begin
            if (cfg_rd)
                cfg_rdata <= nxt_rdata;
            cfg_ack <= cfg_rd | cfg_wr;
            cfg_ext_sel <= (cfg_rd | cfg_wr) & nxt_ext;
            win_hit_socket <= hit_sock[1:0];
            win_hit_legacy <= hit_leg[1:0];
            line_len_out <= line_len_ff[0];
        end
    end

    // ****************************************
    // Initiator tenure limit
    // ****************************************
    reg [2:0] gnt_sync_ff;
    reg gnt_level_ff;
    wire gnt_stable_high;
    wire expired;

    always @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            gnt_sync_ff <= 3'b000;
        else
            gnt_sync_ff <= {gnt_sync_ff[1:0], gnt_n};
    end

    // Grant level only moves once second and third stages agree
    always @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            gnt_level_ff <= 1'b0;
        else if (gnt_sync_ff[1] == gnt_sync_ff[2])
            gnt_level_ff <= gnt_sync_ff[2];
    end
    assign gnt_stable_high = gnt_level_ff;

    cbh_tenure_timer #(
        .WIDTH(8)
    ) u_timer (
        .ref_clk(ref_clk),
        .rst_sync_n(rst_sync_n),
        .frame_start(init_frame_start),
        .xfer_busy(init_busy),
        .limit(tenure_ff[0]),
        .expired(expired)
    );

    always @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            init_end_req <= 1'b0;
        else
            init_end_req <= init_busy & expired & gnt_stable_high;
    end
endmodule // cbh_cfg_header

// [core/cbh_cfg_map.vh]
// Purpose: Offsets, fields, reset values of the bridge header slice 09h-14h
// Assumes: Configuration dword addressing, byte enables active high
// Notes: Definitions only
`ifndef CBH_CFG_MAP_VH
`define CBH_CFG_MAP_VH
// Dword indices
`define CBH_DW_CLASS 6'h02
`define CBH_DW_MISC 6'h03
`define CBH_DW_WINBASE 6'h04
`define CBH_DW_CAP 6'h05
// Byte offsets
`define CBH_OFF_CATEGORY 8'h09
`define CBH_OFF_LINE_LEN 8'h0c
`define CBH_OFF_TENURE 8'h0d
`define CBH_OFF_LAYOUT 8'h0e
`define CBH_OFF_SELF_TEST 8'h0f
`define CBH_OFF_WINBASE 8'h10
`define CBH_OFF_CAP_PTR 8'h14
`define CBH_OFF_EXT_START 8'h80
// Reset and fixed values
`define CBH_RST_CATEGORY 24'h060700
`define CBH_RST_LINE_LEN 8'h00
`define CBH_RST_TENURE 8'h00
`define CBH_RST_LAYOUT 8'h82
`define CBH_RST_SELF_TEST 8'h00
`define CBH_RST_WINBASE 20'h00000
`define CBH_RST_CAP_PTR 8'ha0
// Window base field and socket window decode
`define CBH_WIN_LSB 12
`define CBH_WIN_MSB 31
`define CBH_WIN_SEL_BIT 11
`define CBH_WIN_SOCKET_OFF 12'h000
`define CBH_WIN_LEGACY_OFF 12'h800
`endif

// [core/cbh_tenure_timer.v]
// Purpose: Bus tenure limit counter for the initiator
// Assumes: frame_start pulses on the cycle FRAME is first asserted
// Notes: Counts ref_clk cycles from zero
`timescale 1ns/10ps
module cbh_tenure_timer #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_sync_n,
    // Control
    input wire frame_start,
    input wire xfer_busy,
    input wire [WIDTH-1:0] limit,
    // Status
    output reg expired
);
    reg [WIDTH-1:0] count_ff;
    reg [WIDTH-1:0] nxt_count;
    reg nxt_expired;

    always @*
    begin
        nxt_count = count_ff;
        nxt_expired = expired;
        if (frame_start)
        begin
            nxt_count = {WIDTH{1'b0}};
            nxt_expired = (limit == {WIDTH{1'b0}});
        end
        else if (!xfer_busy)
        begin
            nxt_count = {WIDTH{1'b0}};
            nxt_expired = 1'b0;
        end
        else if (!expired)
        begin
            nxt_count = count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
            nxt_expired = (nxt_count >= limit);
        end
    end

    always @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            count_ff <= {WIDTH{1'b0}};
            expired <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            expired <= nxt_expired;
        end
    end
endmodule // cbh_tenure_timer

// [verif/cbh_cfg_header_assertions.sv]
// Purpose: Port checks of the header slice
// Assumes: One-cycle strobes, ack one cycle later
// Notes: Bound into the header module
`timescale 1ns/10ps
module cbh_cfg_header_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Access
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic [5:0] cfg_dw,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_ack,
    input wire logic cfg_ext_sel,
    // Tenure
    input wire logic gnt_n,
    input wire logic init_end_req
);
    // ********
    // Checks
    // ********
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire logic acc = cfg_rd || cfg_wr;
    ack_after_req_a: assert property (acc |=> cfg_ack) else $error("no ack");
    ack_has_cause_a: assert property (cfg_ack |-> $past(acc)) else $error("stray ack");
    ext_space_a: assert property (acc |=> cfg_ext_sel == $past(cfg_dw[5])) else $error("ext");
    category_fixed_a: assert property (cfg_rd && cfg_dw == 6'h02 |=>
        cfg_rdata[31:8] == 24'h060700) else $error("category");
    layout_fixed_a: assert property (cfg_rd && cfg_dw == 6'h03 |=>
        cfg_rdata[31:16] == 16'h0082) else $error("layout");
    base_low_zero_a: assert property (cfg_rd && cfg_dw == 6'h04 |=>
        cfg_rdata[11:0] == 12'h000) else $error("base low");
    cap_ptr_a: assert property (cfg_rd && cfg_dw == 6'h05 |=>
        cfg_rdata[7:0] == 8'ha0) else $error("cap");
    grant_holds_a: assert property (!gnt_n [*6] |=> !init_end_req) else $error("end");
    cover property (cfg_ext_sel);
    cover property (init_end_req);
    cover property (cfg_ack && cfg_rdata[9]);
endmodule // cbh_cfg_header_chk

bind cbh_cfg_header cbh_cfg_header_chk i_chk (.*);

// [verif/cbh_cfg_header_tb.sv]
// Purpose: Self-checking bench of the header slice
// Assumes: 100 MHz clock, host model drives cycles
// Notes: Window and tenure inputs driven here
`timescale 1ns/10ps
`define CHK(n, e, g) cmp(n, e, g)
module cbh_cfg_header_tb;
    logic ref_clk = 0, rst_n = 0, cfg_rd, cfg_wr, cfg_func, cfg_ack, cfg_ext_sel;
    logic mem_req = 0, init_frame_start = 0, init_busy = 0, gnt_n = 1, init_end_req;
    logic [5:0] cfg_dw;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, q, mem_addr = 0;
    logic [1:0] win_hit_socket, win_hit_legacy;
    logic [7:0] line_len_out;
    int mismatches = 0, check_count = 0;
    always #5 ref_clk = ~ref_clk;
    cbh_cfg_header i_dut (.*);
    cbh_host_model i_host (.*);
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic rc(input logic f, input logic [5:0] d, input logic [31:0] e, string n);
        i_host.xfer(1'b0, f, d, 4'hf, 32'h0, q);
        `CHK(n, e, q);
        `CHK("read ack", 1'b1, i_host.ack_seen);
    endtask
    task automatic wr(input logic f, input logic [5:0] d, input logic [3:0] b, logic [31:0] w);
        i_host.xfer(1'b1, f, d, b, w, q);
        `CHK("write ack", 1'b1, i_host.ack_seen);
    endtask
    task automatic win(input logic [31:0] a, input logic [1:0] s, input logic [1:0] l);
        {mem_addr, mem_req} = {a, 1'b1};
        @(posedge ref_clk);
        #1;
        `CHK("socket", s, win_hit_socket);
        `CHK("legacy", l, win_hit_legacy);
    endtask
    task automatic wc(input int n, input logic e, string s);
        repeat (n) @(posedge ref_clk);
        #1;
        `CHK(s, e, init_end_req);
    endtask
    task automatic end_of_test;
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #50000;
        mismatches++;
        end_of_test;
    end
    initial
    begin
        repeat (4) @(posedge ref_clk);
        #1 rst_n = 1;
        repeat (3) @(posedge ref_clk);
        for (int f = 0; f < 2; f++)
        begin
            rc(f[0], 6'h03, 32'h00820000, "misc");
            rc(f[0], 6'h04, 32'h0, "base");
            wr(f[0], 6'h02, 4'hf, '1);
            wr(f[0], 6'h03, 4'hc, '1);
            wr(f[0], 6'h05, 4'hf, '1);
            rc(f[0], 6'h02, 32'h06070000, "category");
            rc(f[0], 6'h03, 32'h00820000, "ro misc");
            rc(f[0], 6'h05, 32'ha0, "cap");
        end
        wr(1'b0, 6'h03, 4'h3, 32'h00002010);
        wr(1'b1, 6'h03, 4'h3, 32'h00004020);
        rc(1'b0, 6'h03, 32'h00822010, "misc f0");
        rc(1'b1, 6'h03, 32'h00824020, "misc f1");
        `CHK("line copy", 8'h10, line_len_out);
        i_host.idle_gap = 3;
        wr(1'b0, 6'h04, 4'hf, '1);
        wr(1'b1, 6'h04, 4'hf, 32'h12345678);
        wr(1'b1, 6'h04, 4'h2, 32'h0000ab00);
        rc(1'b0, 6'h04, 32'hfffff000, "base f0");
        rc(1'b1, 6'h04, 32'h1234a000, "base f1");
        wr(1'b0, 6'h20, 4'hf, 32'h0);
        `CHK("ext", 1'b1, cfg_ext_sel);
        wr(1'b0, 6'h1f, 4'hf, 32'h0);
        `CHK("std", 1'b0, cfg_ext_sel);
        win(32'h1234a004, 2'b10, 2'b00);
        win(32'h1234a800, 2'b00, 2'b10);
        win(32'hfffff7fc, 2'b01, 2'b00);
        win(32'h00000800, 2'b00, 2'b00);
        {init_frame_start, init_busy} = 2'b11;
        @(posedge ref_clk);
        #1 init_frame_start = 0;
        wc(28, 1'b0, "early end");
        wc(8, 1'b1, "late end");
        gnt_n = 0;
        wc(8, 1'b0, "granted");
        gnt_n = 1;
        wc(8, 1'b1, "released");
        init_busy = 0;
        wc(3, 1'b0, "idle");
        end_of_test;
    end
endmodule // cbh_cfg_header_tb

// [verif/cbh_host_model.sv]
// Purpose: Host issuing configuration cycles
// Assumes: Strobe raised 1 ns after an edge
// Notes: Write data inverted once released
`timescale 1ns/10ps
module cbh_host_model (
    // Clock
    input wire logic ref_clk,
    // Requests
    output logic cfg_rd,
    output logic cfg_wr,
    output logic cfg_func,
    output logic [5:0] cfg_dw,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata,
    // Answers
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_ack
);
    int idle_gap = 0;
    logic ack_seen;
    initial {cfg_rd, cfg_wr, cfg_func, cfg_dw, cfg_be, cfg_wdata} = '0;
    task automatic xfer(input logic w, input logic f, input logic [5:0] d,
        input logic [3:0] b, input logic [31:0] wd, output logic [31:0] q);
        repeat (idle_gap) @(posedge ref_clk);
        @(posedge ref_clk);
        #1;
        cfg_rd = !w;
        cfg_wr = w;
        {cfg_func, cfg_dw, cfg_be, cfg_wdata} = {f, d, b, wd};
        @(posedge ref_clk);
        #1;
        {cfg_rd, cfg_wr} = 2'b00;
        cfg_wdata = ~wd;
        q = cfg_rdata;
        ack_seen = cfg_ack;
    endtask
endmodule // cbh_host_model
